// File: core/dsi_regs.vh
// Register map, field positions, reset values and timing counts of the status indicator block
`ifndef DSI_REGS_VH
`define DSI_REGS_VH

// ==========================================================
// Register offsets (word index on the plain register port)
`define DSI_REG_MODE      4'h0
`define DSI_REG_SELA      4'h1
`define DSI_REG_SELB      4'h2
`define DSI_REG_INV       4'h3
`define DSI_REG_DLYA      4'h4
`define DSI_REG_DLYB      4'h5
`define DSI_REG_GEAR      4'h6
`define DSI_REG_ILKT      4'h7
`define DSI_REG_STATE     4'h8
`define DSI_REG_IRQST     4'h9
`define DSI_REG_IRQMSK    4'ha

// ==========================================================
// Mode codes (8-bit two's complement)
`define DSI_MODE_NONE     8'hff
`define DSI_MODE_PHASE    8'h00
`define DSI_MODE_STATUS   8'h08

// ==========================================================
// Reset values
`define DSI_RST_MODE      8'h00
`define DSI_RST_SEL       8'h80
`define DSI_RST_INV       2'h0
`define DSI_RST_DLY       8'h00
`define DSI_RST_GEAR      16'h0101
`define DSI_RST_GEAR_A    8'h01
`define DSI_RST_GEAR_B    8'h01
`define DSI_RST_ILKT      8'h0a
`define DSI_SEL_CONST_OFF 8'h80
`define DSI_SEL_CONST_ON  8'h81

// ==========================================================
// Field positions
`define DSI_INV_A         0
`define DSI_INV_B         1
`define DSI_IRQ_ALARM     0
`define DSI_IRQ_POWREM    1
`define DSI_IRQ_INFO      2

// ==========================================================
// Timing: clock 25 MHz, 1 ms tick, blink 250 ms, tenth 100 ms
`define DSI_CLK_HZ        25000000
`define DSI_TICK_MS       1
`define DSI_TICK_CYC      (`DSI_CLK_HZ / 1000 * `DSI_TICK_MS)
`define DSI_MAX_DLY_MS    250
`define DSI_BLINK_MS      250
`define DSI_TENTH_MS      100
`define DSI_PAUSE_SLOTS   4'h6

`endif

// File: core/dsi_off_delay.v
// OFF-delay stage for one status channel
`timescale 1ns/1ps
`default_nettype none
`include "dsi_regs.vh"
module dsi_off_delay (
   // Clock and reset
   input  wire       sys_clk,
   input  wire       reset,
   // Delay in ms and signal
   input  wire [7:0] delayMs,
   input  wire       sigIn,
   output reg        sigOut_ff
);
   reg  [7:0]  cnt_ff;
   reg  [14:0] subCnt_ff;
   wire [7:0]  lim    = (delayMs > `DSI_MAX_DLY_MS) ? 8'hfa : delayMs;
   wire        msDone = (subCnt_ff == `DSI_TICK_CYC - 1);

   // ON passes at once; OFF waits whole ms counted from the fall, not from a shared tick
   always @(posedge sys_clk) begin
      if (reset) begin
         sigOut_ff <= 1'b0;
         cnt_ff    <= 8'h00;
         subCnt_ff <= 15'h0000;
      end else if (sigIn) begin
         sigOut_ff <= 1'b1;
         cnt_ff    <= 8'h00;
         subCnt_ff <= 15'h0000;
      end else if (sigOut_ff) begin
         if (cnt_ff >= lim) begin
            sigOut_ff <= 1'b0;
         end else if (msDone) begin
            cnt_ff    <= cnt_ff + 8'h01;
            subCnt_ff <= 15'h0000;
         end else begin
            subCnt_ff <= subCnt_ff + 15'h0001;
         end
      end
   end
endmodule // dsi_off_delay
`default_nettype wire

// File: core/dsi_status_indicator.v
// Differential phase/status output and power/alarm indicator encoder
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dsi_regs.vh"
module dsi_status_indicator (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        reset,
   // Register port
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrStb,
   input  wire        regRdStb,
   output reg  [15:0] regRdData_ff,
   // Feedback position and internal signals
   input  wire [31:0] feedbackPos,
   input  wire [127:0] statusSignals,
   // Driver conditions
   input  wire        alarmActive,
   input  wire [3:0]  alarmBlinkCount,
   input  wire        powerRemoval,
   input  wire        infoActive,
   input  wire        teachActive,
   input  wire        interlockReleased,
   input  wire        switchExecuting,
   input  wire        simMode,
   // Differential outputs
   output reg         phase_a_out,
   output reg         phase_b_out,
   output reg         diff_status_chan_a,
   output reg         diff_status_chan_b,
   output reg         diffOutEnable,
   // Indicator
   output reg         ledGreen_ff,
   output reg         ledRed_ff,
   // Interrupt
   output wire        irqOut
);
   // ==========================================================
   // Configuration registers
   reg  [7:0]  mode_ff;
   reg  [7:0]  selA_ff;
   reg  [7:0]  selB_ff;
   reg  [1:0]  inv_ff;
   reg  [7:0]  dlyA_ff;
   reg  [7:0]  dlyB_ff;
   reg  [7:0]  gearA_ff;
   reg  [7:0]  gearB_ff;
   reg  [7:0]  ilkTime_ff;
   reg  [2:0]  irqSt_ff;
   reg  [2:0]  irqMsk_ff;
   reg  [2:0]  evPrev_ff;
   wire [2:0]  evNow = {infoActive | teachActive, powerRemoval, alarmActive};
   wire [2:0]  evRise = evNow & ~evPrev_ff;
   wire        wrIrq = regWrStb && (regAddr == `DSI_REG_IRQST);
   reg  [2:0]  pattern;

   // Register writes; sticky status, set wins over clear
   always @(posedge sys_clk) begin
      if (reset) begin
         mode_ff    <= `DSI_RST_MODE;
         selA_ff    <= `DSI_RST_SEL;
         selB_ff    <= `DSI_RST_SEL;
         inv_ff     <= `DSI_RST_INV;
         dlyA_ff    <= `DSI_RST_DLY;
         dlyB_ff    <= `DSI_RST_DLY;
         gearA_ff   <= `DSI_RST_GEAR_A;
         gearB_ff   <= `DSI_RST_GEAR_B;
         ilkTime_ff <= `DSI_RST_ILKT;
         irqSt_ff   <= 3'h0;
         irqMsk_ff  <= 3'h0;
         evPrev_ff  <= 3'h0;
      end else begin
         evPrev_ff <= evNow;
         irqSt_ff  <= (irqSt_ff & ~(wrIrq ? regWrData[2:0] : 3'h0)) | evRise;
         if (regWrStb) begin
            case (regAddr)
               `DSI_REG_MODE:   mode_ff    <= regWrData[7:0];
               `DSI_REG_SELA:   selA_ff    <= regWrData[7:0];
               `DSI_REG_SELB:   selB_ff    <= regWrData[7:0];
               `DSI_REG_INV:    inv_ff     <= regWrData[1:0];
               `DSI_REG_DLYA:   dlyA_ff    <= (regWrData > 16'h00fa) ? 8'hfa : regWrData[7:0];
               `DSI_REG_DLYB:   dlyB_ff    <= (regWrData > 16'h00fa) ? 8'hfa : regWrData[7:0];
               `DSI_REG_GEAR: begin
                  gearA_ff <= regWrData[15:8];
                  gearB_ff <= regWrData[7:0];
               end
               `DSI_REG_ILKT:   ilkTime_ff <= (regWrData > 16'h0032) ? 8'h32 : regWrData[7:0];
               `DSI_REG_IRQMSK: irqMsk_ff  <= regWrData[2:0];
               default: ;
            endcase
         end
      end
   end

   // Read data one cycle after the strobe
   always @(posedge sys_clk) begin
      if (reset) begin
         regRdData_ff <= 16'h0000;
      end else if (regRdStb) begin
         case (regAddr)
            `DSI_REG_MODE:   regRdData_ff <= {8'h00, mode_ff};
            `DSI_REG_SELA:   regRdData_ff <= {8'h00, selA_ff};
            `DSI_REG_SELB:   regRdData_ff <= {8'h00, selB_ff};
            `DSI_REG_INV:    regRdData_ff <= {14'h0000, inv_ff};
            `DSI_REG_DLYA:   regRdData_ff <= {8'h00, dlyA_ff};
            `DSI_REG_DLYB:   regRdData_ff <= {8'h00, dlyB_ff};
            `DSI_REG_GEAR:   regRdData_ff <= {gearA_ff, gearB_ff};
            `DSI_REG_ILKT:   regRdData_ff <= {8'h00, ilkTime_ff};
            `DSI_REG_STATE:  regRdData_ff <= {8'h00, ledRed_ff, ledGreen_ff, 3'h0, pattern};
            `DSI_REG_IRQST:  regRdData_ff <= {13'h0000, irqSt_ff};
            `DSI_REG_IRQMSK: regRdData_ff <= {13'h0000, irqMsk_ff};
            default:         regRdData_ff <= 16'h0000;
         endcase
      end else begin
         regRdData_ff <= 16'h0000;
      end
   end

   // A set mask bit blocks its status bit
   assign irqOut = |(irqSt_ff & ~irqMsk_ff);

   // ==========================================================
   // Millisecond tick
   reg  [14:0] tickCnt_ff;
   wire        msTick = (tickCnt_ff == `DSI_TICK_CYC - 1);
   always @(posedge sys_clk) begin
      if (reset || msTick) begin
         tickCnt_ff <= 15'h0000;
      end else begin
         tickCnt_ff <= tickCnt_ff + 15'h0001;
      end
   end

   // ==========================================================
   // Quadrature encoder; position scaled by gearA/gearB
   reg  [39:0] scaled_ff;
   reg  [31:0] quadPos_ff;
   always @(posedge sys_clk) begin
      if (reset) begin
         scaled_ff  <= 40'h0;
         quadPos_ff <= 32'h0;
      end else begin
         scaled_ff <= feedbackPos * gearA_ff;
         if (gearB_ff != 8'h00) begin
            quadPos_ff <= scaled_ff[31:0] / gearB_ff;
         end
      end
   end

   // Gray code of the two low bits gives A/B with direction
   wire quadA = quadPos_ff[1] ^ quadPos_ff[0];
   wire quadB = quadPos_ff[1];

   // ==========================================================
   // Status channels: select, OFF delay, invert
   wire selSigA = (selA_ff == `DSI_SEL_CONST_OFF) ? 1'b0 :
                  (selA_ff[7] ? 1'b0 : statusSignals[selA_ff[6:0]]);
   wire selSigB = (selB_ff == `DSI_SEL_CONST_OFF) ? 1'b0 :
                  (selB_ff[7] ? 1'b0 : statusSignals[selB_ff[6:0]]);
   wire dlyOutA;
   wire dlyOutB;
   dsi_off_delay u_delayA (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .delayMs   (dlyA_ff),
      .sigIn     (selSigA),
      .sigOut_ff (dlyOutA)
   );
   dsi_off_delay u_delayB (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .delayMs   (dlyB_ff),
      .sigIn     (selSigB),
      .sigOut_ff (dlyOutB)
   );

   // Output multiplexer per mode
   always @(posedge sys_clk) begin
      if (reset) begin
         phase_a_out        <= 1'b0;
         phase_b_out        <= 1'b0;
         diff_status_chan_a <= 1'b0;
         diff_status_chan_b <= 1'b0;
         diffOutEnable      <= 1'b0;
      end else begin
         phase_a_out        <= 1'b0;
         phase_b_out        <= 1'b0;
         diff_status_chan_a <= 1'b0;
         diff_status_chan_b <= 1'b0;
         diffOutEnable      <= 1'b0;
         case (mode_ff)
            `DSI_MODE_PHASE: begin
               phase_a_out   <= quadA;
               phase_b_out   <= quadB;
               diffOutEnable <= 1'b1;
            end
            `DSI_MODE_STATUS: begin
               diff_status_chan_a <= dlyOutA ^ inv_ff[`DSI_INV_A];
               diff_status_chan_b <= dlyOutB ^ inv_ff[`DSI_INV_B];
               diffOutEnable      <= 1'b1;
            end
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Indicator timebase: 250 ms slots
   reg  [7:0]  slotMs_ff;
   reg  [4:0]  slot_ff;
   reg         blink_ff;
   wire        slotTick = msTick && (slotMs_ff == `DSI_BLINK_MS - 1);
   always @(posedge sys_clk) begin
      if (reset) begin
         slotMs_ff <= 8'h00;
         slot_ff   <= 5'h00;
         blink_ff  <= 1'b0;
      end else if (msTick) begin
         slotMs_ff <= slotTick ? 8'h00 : slotMs_ff + 8'h01;
         if (slotTick) begin
            slot_ff  <= slot_ff + 5'h01;
            blink_ff <= ~blink_ff;
         end
      end
   end

   // Alarm burst: count on/off pairs then a pause
   reg  [5:0]  almSlot_ff;
   wire [5:0]  almLen = {1'b0, alarmBlinkCount, 1'b0} + {2'b00, `DSI_PAUSE_SLOTS}; // Six bits: 15 pairs plus pause
   always @(posedge sys_clk) begin
      if (reset || !alarmActive) begin
         almSlot_ff <= 6'h00;
      end else if (slotTick) begin
         almSlot_ff <= (almSlot_ff >= almLen - 6'h01) ? 6'h00 : almSlot_ff + 6'h01;
      end
   end
   wire almOn = (almSlot_ff < {1'b0, alarmBlinkCount, 1'b0}) && !almSlot_ff[0];

   // Interlock release window in tenths of a second
   reg  [6:0]  ilkMs_ff;
   reg  [5:0]  ilkTenth_ff;
   reg         ilkShow_ff;
   reg         ilkPrev_ff;
   always @(posedge sys_clk) begin
      if (reset) begin
         ilkMs_ff    <= 7'h00;
         ilkTenth_ff <= 6'h00;
         ilkShow_ff  <= 1'b0;
         ilkPrev_ff  <= 1'b0;
      end else begin
         ilkPrev_ff <= interlockReleased;
         if (interlockReleased && !ilkPrev_ff && ilkTime_ff != 8'h00) begin
            ilkShow_ff  <= 1'b1;
            ilkMs_ff    <= 7'h00;
            ilkTenth_ff <= 6'h00;
         end else if (ilkShow_ff && msTick) begin
            if (ilkMs_ff == `DSI_TENTH_MS - 1) begin
               ilkMs_ff    <= 7'h00;
               ilkTenth_ff <= ilkTenth_ff + 6'h01;
               if ({2'b00, ilkTenth_ff} + 8'h01 >= ilkTime_ff) begin
                  ilkShow_ff <= 1'b0;
               end
            end else begin
               ilkMs_ff <= ilkMs_ff + 7'h01;
            end
         end
      end
   end

   // ==========================================================
   // Pattern priority and LED drive
   localparam P_NORMAL = 3'h0;
   localparam P_ALARM  = 3'h1;
   localparam P_POWREM = 3'h2;
   localparam P_INFO   = 3'h3;
   localparam P_ILK    = 3'h4;
   localparam P_EXEC   = 3'h5;
   localparam P_SIM    = 3'h6;
   always @* begin
      if (simMode)                       pattern = P_SIM;
      else if (alarmActive)              pattern = P_ALARM;
      else if (powerRemoval)             pattern = P_POWREM;
      else if (infoActive || teachActive) pattern = P_INFO;
      else if (ilkShow_ff)               pattern = P_ILK;
      else if (switchExecuting)          pattern = P_EXEC;
      else                               pattern = P_NORMAL;
   end

   // Double blink: slots 0 and 2 of each 8-slot group
   wire dblOn = (slot_ff[2:0] == 3'h0) || (slot_ff[2:0] == 3'h2);
   always @(posedge sys_clk) begin
      if (reset) begin
         ledGreen_ff <= 1'b0;
         ledRed_ff   <= 1'b0;
      end else begin
         case (pattern)
            P_ALARM:  begin ledGreen_ff <= 1'b0;     ledRed_ff <= almOn;    end
            P_POWREM: begin ledGreen_ff <= blink_ff; ledRed_ff <= 1'b0;     end
            P_INFO:   begin ledGreen_ff <= dblOn;    ledRed_ff <= dblOn;    end
            P_ILK:    begin ledGreen_ff <= blink_ff; ledRed_ff <= blink_ff; end
            P_EXEC:   begin ledGreen_ff <= 1'b1;     ledRed_ff <= 1'b1;     end
            P_SIM: begin
               ledGreen_ff <= (slot_ff[1:0] == 2'h0) || (slot_ff[1:0] == 2'h2);
               ledRed_ff   <= (slot_ff[1:0] == 2'h1) || (slot_ff[1:0] == 2'h2);
            end
            default:  begin ledGreen_ff <= 1'b1;     ledRed_ff <= 1'b0;     end
         endcase
      end
   end
endmodule // dsi_status_indicator
`default_nettype wire

// File: bench/dsi_status_indicator_sva.sv
// Port-level assertion checker for the status indicator block
`timescale 1ns/1ps
`default_nettype none
module dsi_status_indicator_sva (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   // Register read side
   input wire logic        regRdStb,
   input wire logic [15:0] regRdData_ff,
   // Driver conditions
   input wire logic        alarmActive,
   input wire logic        powerRemoval,
   input wire logic        infoActive,
   input wire logic        teachActive,
   input wire logic        interlockReleased,
   input wire logic        switchExecuting,
   input wire logic        simMode,
   // Differential pair and indicator
   input wire logic        phase_a_out,
   input wire logic        phase_b_out,
   input wire logic        diff_status_chan_a,
   input wire logic        diff_status_chan_b,
   input wire logic        diffOutEnable,
   input wire logic        ledGreen_ff,
   input wire logic        ledRed_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ==========================================================
   // Indicator condition sequences
   sequence quiet_s;
      !(alarmActive || powerRemoval || infoActive || teachActive || switchExecuting || simMode);
   endsequence
   sequence execOnly_s;
      (switchExecuting && !(alarmActive || powerRemoval || infoActive || teachActive || simMode)) [*4];
   endsequence
   sequence idle_s;
      (!interlockReleased && !(alarmActive || powerRemoval || infoActive || teachActive || switchExecuting
         || simMode)) [*4];
   endsequence
   // ==========================================================
   // Assertions
   rd_idle_zero_a: assert property (!$past(regRdStb) |-> regRdData_ff == 16'h0000)
      else $error("read data not zero outside its slot");
   enable_after_reset_a: assert property ($fell(reset) |-> ##[0:2] diffOutEnable)
      else $error("pair not enabled after reset");
   phase_needs_en_a: assert property ((phase_a_out || phase_b_out) |-> diffOutEnable)
      else $error("phase output while pair disabled");
   status_needs_en_a: assert property ((diff_status_chan_a || diff_status_chan_b) |-> diffOutEnable)
      else $error("status output while pair disabled");
   status_excl_phase_a: assert property ((diff_status_chan_a || diff_status_chan_b) |->
      !(phase_a_out || phase_b_out)) else $error("phase and status outputs together");
   led_reset_dark_a: assert property (disable iff (1'b0) reset |=> !ledGreen_ff && !ledRed_ff)
      else $error("indicator lit during reset");
   green_after_reset_a: assert property ($fell(reset) ##0 quiet_s |-> ##[0:2] ledGreen_ff && !ledRed_ff)
      else $error("no green after reset");
   normal_green_a: assert property (idle_s |-> ledGreen_ff && !ledRed_ff)
      else $error("normal state not steady green");
   exec_both_a: assert property (execOnly_s |-> ledGreen_ff && ledRed_ff)
      else $error("switch execution not both lit");
endmodule // dsi_status_indicator_sva

bind dsi_status_indicator dsi_status_indicator_sva chk_u (.sys_clk, .reset, .regRdStb, .regRdData_ff,
   .alarmActive, .powerRemoval, .infoActive, .teachActive, .interlockReleased, .switchExecuting, .simMode,
   .phase_a_out, .phase_b_out, .diff_status_chan_a, .diff_status_chan_b, .diffOutEnable, .ledGreen_ff,
   .ledRed_ff);
`default_nettype wire

// File: bench/dsi_quad_receiver.sv
// Quadrature receiver model standing on the far side of the differential pair
`timescale 1ns/1ps
`default_nettype none
module dsi_quad_receiver (
   // Clock
   input  wire logic        sys_clk,
   // Differential phase pair
   input  wire logic        phaseA,
   input  wire logic        phaseB,
   // Recovered position and skipped-state flag
   output var  logic [31:0] posCount,
   output var  logic        stepErr
);
   logic [1:0] prevIdx;
   logic [1:0] curIdx;
   initial begin
      posCount = 32'h0000_0000;
      stepErr = 1'b0;
      prevIdx = 2'h0;
   end
   // Gray index of the pair, up count when A leads B
   assign curIdx = {phaseB, phaseA ^ phaseB};
   // Count a step per index change, flag a jump of two
   always @(posedge sys_clk) begin
      if (curIdx == prevIdx + 2'h1)
         posCount <= posCount + 32'h1;
      else if (curIdx == prevIdx - 2'h1)
         posCount <= posCount - 32'h1;
      else if (curIdx != prevIdx)
         stepErr <= 1'b1;
      prevIdx <= curIdx;
   end
endmodule // dsi_quad_receiver
`default_nettype wire

// File: bench/dsi_status_indicator_test.sv
// Self-checking testbench of the status indicator block
`timescale 1ns/1ps
`default_nettype none
`include "dsi_regs.vh"
module dsi_status_indicator_test;
   logic         sys_clk = 1'b0;
   logic         reset = 1'b1;
   logic [3:0]   regAddr = 4'h0;
   logic [15:0]  regWrData = 16'h0000;
   logic         regWrStb = 1'b0;
   logic         regRdStb = 1'b0;
   logic [31:0]  feedbackPos = 32'h0;
   logic [127:0] statusSignals = '0;
   logic [3:0]   alarmBlinkCount = 4'h3;
   logic         interlockReleased = 1'b0;
   logic [5:0]   cnd = 6'h00; // {sim, alarm, power removal, info, teach, exec}
   wire  [15:0]  regRdData_ff;
   wire  [31:0]  posCount;
   wire          phA, phB, stA, stB, outEn, ledG, ledR, irq, stepErr;
   int           err_total = 0;
   int           n_compared = 0;
   int           cycN = 0;
   integer       seedV = 32'hd17b;
   int           i, k, selA, selB;
   logic [15:0]  rdv;
   logic [15:0]  oldCnt;
   logic [5:0]   cndTab [0:8] = '{6'h10, 6'h08, 6'h04, 6'h02, 6'h01, 6'h1f, 6'h20, 6'h30, 6'h00};
   logic [7:0]   modeTab [0:3] = '{8'hff, 8'h05, 8'h00, 8'h08};

   dsi_status_indicator dut_u (.sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_ff(regRdData_ff), .feedbackPos(feedbackPos),
      .statusSignals(statusSignals), .alarmActive(cnd[4]), .alarmBlinkCount(alarmBlinkCount),
      .powerRemoval(cnd[3]), .infoActive(cnd[2]), .teachActive(cnd[1]), .interlockReleased(interlockReleased),
      .switchExecuting(cnd[0]), .simMode(cnd[5]), .phase_a_out(phA), .phase_b_out(phB),
      .diff_status_chan_a(stA), .diff_status_chan_b(stB), .diffOutEnable(outEn), .ledGreen_ff(ledG),
      .ledRed_ff(ledR), .irqOut(irq));
   dsi_quad_receiver rx_u (.sys_clk(sys_clk), .phaseA(phA), .phaseB(phB), .posCount(posCount),
      .stepErr(stepErr));

   // ==========================================================
   // Clock, watchdog and shared tasks
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycN++;
      if (cycN == 60000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0, got}, {15'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   endtask
   task automatic rdChk(input logic [3:0] a, input logic [15:0] exp, input logic [15:0] msk);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 rdv = regRdData_ff;
      chk16(rdv & msk, exp);
   endtask
   function automatic logic [15:0] rstVal(input int a);
      case (a)
         1, 2: return {8'h00, `DSI_RST_SEL};
         6: return `DSI_RST_GEAR;
         7: return {8'h00, `DSI_RST_ILKT};
         8: return 16'h0040;
         default: return 16'h0000;
      endcase
   endfunction
   function automatic logic [15:0] expPat(input logic [5:0] c);
      if (c[5]) return 16'h0006;
      if (c[4]) return 16'h0001;
      if (c[3]) return 16'h0002;
      if (c[2] || c[1]) return 16'h0003;
      if (c[0]) return 16'h0005;
      return 16'h0000;
   endfunction

   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      cyc(3);
      chk1(outEn & ledG & !ledR, 1'b1);
      for (i = 0; i < 16; i++) if (i != 10) rdChk(i[3:0], rstVal(i), 16'hffff);
      $display("test reset values done");
      wr(`DSI_REG_GEAR, 16'h0101);
      for (i = 0; i < 200; i++) begin
         @(posedge sys_clk);
         feedbackPos <= feedbackPos + ((($random(seedV) & 1) != 0) ? 32'h1 : 32'hffff_ffff);
         repeat (i % 3) @(posedge sys_clk);
      end
      cyc(8);
      chk16(posCount[15:0], feedbackPos[15:0]);
      chk1(stepErr, 1'b0);
      wr(`DSI_REG_GEAR, 16'h0100);
      oldCnt = posCount[15:0];
      @(posedge sys_clk);
      feedbackPos <= feedbackPos + 32'h5;
      cyc(8);
      chk16(posCount[15:0], oldCnt);
      $display("test phase output done");
      for (k = 0; k < 4; k++) begin
         wr(`DSI_REG_MODE, {8'h00, modeTab[k]});
         cyc(4);
         chk1(outEn, modeTab[k] == 8'h00 || modeTab[k] == 8'h08);
         if (k < 2) chk1(phA | phB | stA | stB, 1'b0);
      end
      rdChk(`DSI_REG_MODE, 16'h0008, 16'hffff);
      @(posedge sys_clk);
      statusSignals <= '1;
      cyc(4);
      chk1(stA | stB, 1'b0);
      selA = $random(seedV) & 32'h7f;
      selB = selA ^ 1;
      wr(`DSI_REG_SELA, selA[15:0]);
      wr(`DSI_REG_SELB, selB[15:0]);
      for (k = 0; k < 12; k++) begin
         wr(`DSI_REG_INV, {14'h0, k[1:0]});
         @(posedge sys_clk);
         statusSignals <= {$random(seedV), $random(seedV), $random(seedV), $random(seedV)};
         alarmBlinkCount <= 4'($random(seedV));
         cyc(4);
         chk1(stA, statusSignals[selA] ^ k[0]);
         chk1(stB, statusSignals[selB] ^ k[1]);
      end
      wr(`DSI_REG_DLYA, 16'h012c);
      rdChk(`DSI_REG_DLYA, 16'h00fa, 16'hffff);
      wr(`DSI_REG_DLYA, 16'h0001);
      wr(`DSI_REG_SELB, selA[15:0]);
      wr(`DSI_REG_INV, 16'h0000);
      @(posedge sys_clk);
      statusSignals <= 128'h1 << selA;
      cyc(4);
      chk1(stA & stB, 1'b1);
      @(posedge sys_clk);
      statusSignals <= '0;
      cyc(4);
      chk1(stA, 1'b1);
      chk1(stB, 1'b0);
      for (k = 0; k < 25100 && stA !== 1'b0; k++) cyc(1);
      chk1(k >= `DSI_TICK_CYC - 4 && k <= `DSI_TICK_CYC, 1'b1);
      cyc(1);
      chk1(stA, 1'b0);
      $display("test status output done");
      for (k = 0; k < 9; k++) begin
         @(posedge sys_clk);
         cnd <= cndTab[k];
         cyc(6);
         rdChk(`DSI_REG_STATE, expPat(cndTab[k]), 16'h0007);
         if (cndTab[k][5:4] == 2'b01) chk1(ledG, 1'b0);
         if (cndTab[k] == 6'h08) chk1(ledR, 1'b0);
         if (cndTab[k] == 6'h01) chk1(ledG & ledR, 1'b1);
      end
      chk1(ledG & !ledR, 1'b1);
      wr(`DSI_REG_IRQMSK, 16'h0000);
      wr(`DSI_REG_IRQST, 16'h0007);
      cyc(1);
      chk1(irq, 1'b0);
      @(posedge sys_clk);
      cnd <= 6'h02;
      cyc(3);
      chk1(irq, 1'b1);
      rdChk(`DSI_REG_IRQST, 16'h0004, 16'h0007);
      wr(`DSI_REG_IRQMSK, 16'h0004);
      cyc(1);
      chk1(irq, 1'b0);
      wr(`DSI_REG_IRQST, 16'h0004);
      wr(`DSI_REG_IRQMSK, 16'h0000);
      cyc(1);
      chk1(irq, 1'b0);
      @(posedge sys_clk);
      cnd <= 6'h00;
      $display("test indicator patterns done");
      wr(`DSI_REG_ILKT, 16'h003c);
      rdChk(`DSI_REG_ILKT, 16'h0032, 16'hffff);
      wr(`DSI_REG_ILKT, 16'h0000);
      @(posedge sys_clk);
      interlockReleased <= 1'b1;
      cyc(4);
      rdChk(`DSI_REG_STATE, 16'h0000, 16'h0007);
      @(posedge sys_clk);
      interlockReleased <= 1'b0;
      wr(`DSI_REG_ILKT, 16'h0001);
      @(posedge sys_clk);
      interlockReleased <= 1'b1;
      cyc(4);
      rdChk(`DSI_REG_STATE, 16'h0004, 16'h0007);
      $display("test interlock done");
      give_verdict();
   end
endmodule // dsi_status_indicator_test
`default_nettype wire
